/* File: design/dcx_defines.svh */
// constants for the instruction execution unit
// assumes inclusion by bare name from design files
`ifndef DCX_DEFINES_SVH
`define DCX_DEFINES_SVH
`define DCX_CYC_POP_D 2'h2
`define DCX_CYC_PUSH_D 2'h2
`define DCX_CYC_RET 2'h3
`define DCX_CYC_RET_FAST 2'h2
`define DCX_ACC_MSB 39
`define DCX_ACC_SAT_BIT 31
`define DCX_STATUS_RESET 16'h0000
`define DCX_LIT5_MASK 16'h001f
`define DCX_SP_RESET 16'h0800
`define DCX_SP_STEP 16'h0002
`define DCX_ZERO_ACC 40'h00_0000_0000
`define DCX_ZERO_REP 16'h0000
`define DCX_ONE_REP 16'h0001
`endif

/* File: design/dcx_pkg.sv */
// types shared by the instruction execution unit
// assumes dcx_defines.svh supplies numeric constants
package dcx_pkg;
    typedef enum logic [4:0] {
        dcx_op_nop,
        dcx_op_acc_multiply,
        dcx_op_acc_square,
        dcx_op_acc_multiply_negated,
        dcx_op_acc_multiply_subtract,
        dcx_op_int_multiply,
        dcx_op_int_multiply_lit5,
        dcx_op_pop_double,
        dcx_op_push_double,
        dcx_op_pop_shadow,
        dcx_op_push_shadow,
        dcx_op_repeat_lit,
        dcx_op_repeat_reg,
        dcx_op_return,
        dcx_op_power_save_op,
        dcx_op_reset,
        dcx_op_rotate_left_carry,
        dcx_op_rotate_left_plain,
        dcx_op_rotate_right_carry
    } dcx_op_t;

    typedef enum logic [1:0] {
        dcx_st_idle,
        dcx_st_second,
        dcx_st_third
    } dcx_state_t;

    typedef struct packed {
        logic c;
        logic n;
        logic z;
        logic acc_a_overflow;
        logic acc_b_overflow;
        logic acc_a_saturate;
        logic acc_b_saturate;
    } dcx_flags_t;
endpackage : dcx_pkg

/* File: design/dcx_mult.sv */
// 17x17 signed multiplier used for all signedness combinations
// extends each 16-bit operand to 17 bits using its own signedness input
`timescale 1ns/1ps
module dcx_mult (
    // operands
    input wire logic [15:0] a_i,
    input wire logic [15:0] b_i,
    input wire logic a_signed_i,
    input wire logic b_signed_i,
    // product
    output logic [31:0] p_o
);
    logic signed [16:0] a_ext;
    logic signed [16:0] b_ext;
    logic signed [33:0] prod;

    always_comb begin
        a_ext = {a_signed_i & a_i[15], a_i};
        b_ext = {b_signed_i & b_i[15], b_i};
        prod = a_ext * b_ext;
        p_o = prod[31:0];
    end
endmodule : dcx_mult

/* File: design/dcx_exec.sv */
// instruction execution unit: multiplies, stack pairs, repeat, returns, power save, reset, rotates
// assumes a decoded op, operand values and register indices come from the fetch stage on ref_clk_i
// Function
// - multiply two registers into chosen accumulator; update overflow flag, saturation flag kept
// - square a register into chosen accumulator; update same accumulator flags
// - load accumulator with negated product; leave all flags unchanged
// - subtract product from accumulator; update flags; write back other accumulator
// - integer multiply, four signedness combinations, 32-bit result to register pair
// - five-bit literal treated unsigned, multiplied, result to register pair
// - double pop moves two stack words into register pair in three cycles
// - double push stores register pair to stack in two cycles, flags kept
// - shadow restore in one cycle may change all flags; save changes none
// - repeat with literal runs next instruction literal plus one times
// - repeat by register runs next instruction register plus one times
// - returns take three cycles, two in fast case, flags kept
// - power save literal picks sleep or idle; affects watchdog and sleep flags
// - software reset in one cycle requests full device reset, flags kept
// - rotate left through carry updates carry, negative, zero
// - rotate right through carry updates carry, negative, zero
`timescale 1ns/1ps
`include "dcx_defines.svh"
module dcx_exec (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    // decoded instruction
    input wire logic op_valid_i,
    input wire dcx_pkg::dcx_op_t op_i,
    input wire logic acc_sel_i,
    input wire logic [3:0] dst_idx_i,
    input wire logic [15:0] src_a_i,
    input wire logic [15:0] src_b_i,
    input wire logic a_signed_i,
    input wire logic b_signed_i,
    input wire logic [13:0] lit14_i,
    input wire logic [4:0] lit5_i,
    input wire logic lit1_i,
    input wire logic ret_fast_i,
    input wire logic [15:0] stack_rd_i,
    // results
    output logic wr_en_o,
    output logic [3:0] wr_idx_o,
    output logic [15:0] wr_data_o,
    output logic stack_wr_o,
    output logic [15:0] stack_wr_data_o,
    output logic [15:0] stack_ptr_o,
    output logic [39:0] acc_a_o,
    output logic [39:0] acc_b_o,
    output logic c_o,
    output logic n_o,
    output logic z_o,
    output logic acc_a_overflow_o,
    output logic acc_b_overflow_o,
    output logic acc_ab_overflow_o,
    output logic acc_a_saturate_o,
    output logic acc_b_saturate_o,
    output logic acc_ab_saturate_o,
    output logic watchdog_timeout_flag_o,
    output logic sleep_flag_o,
    output logic idle_flag_o,
    output logic soft_reset_o,
    // sequencing
    output logic busy_o,
    output logic reissue_o,
    output logic [15:0] repeat_count_o
);
    typedef struct packed {
        dcx_pkg::dcx_state_t st;
        logic [1:0] cyc;
        logic [3:0] pair_idx;
        logic [15:0] hi_word;
        logic wr_en;
        logic [3:0] wr_idx;
        logic [15:0] wr_data;
        logic stack_wr;
        logic [15:0] stack_wr_data;
        logic [15:0] sp;
        logic [39:0] acc_a;
        logic [39:0] acc_b;
        dcx_pkg::dcx_flags_t fl;
        dcx_pkg::dcx_flags_t shadow;
        logic ab_ovf;
        logic ab_sat;
        logic watchdog_timeout_flag;
        logic sleep;
        logic idle;
        logic soft_reset;
        logic busy;
        logic reissue;
        logic [15:0] rep;
    } dcx_exec_state_t;

    dcx_exec_state_t r;
    dcx_exec_state_t next_r;
    logic [31:0] prod;
    logic [15:0] mul_b;
    logic [39:0] prod_ext;
    logic [39:0] acc_new;
    logic [15:0] rot;
    logic ovf;
    logic sat;
    logic mul_b_signed;

    // one multiplier serves accumulator and integer forms; the literal path forces b unsigned
    dcx_mult u_mult (
        .a_i(src_a_i),
        .b_i(mul_b),
        .a_signed_i(a_signed_i),
        .b_signed_i(mul_b_signed),
        .p_o(prod)
    );

    always_comb begin
        mul_b = src_b_i;
        mul_b_signed = b_signed_i;
        if (op_i == dcx_pkg::dcx_op_acc_square) begin
            mul_b = src_a_i;
            mul_b_signed = a_signed_i;
        end else if (op_i == dcx_pkg::dcx_op_int_multiply_lit5) begin
            mul_b = {11'h000, lit5_i} & `DCX_LIT5_MASK;
            mul_b_signed = 1'b0;
        end
    end

    always_comb begin
        next_r = r;
        next_r.wr_en = 1'b0;
        next_r.stack_wr = 1'b0;
        next_r.soft_reset = 1'b0;
        prod_ext = {{8{prod[31]}}, prod};
        acc_new = `DCX_ZERO_ACC;
        rot = 16'h0000;
        ovf = 1'b0;
        sat = 1'b0;
        unique case (r.st)
            dcx_pkg::dcx_st_idle: begin
                if (op_valid_i) begin
                    // each valid op taken while a repeat is pending decrements the count; reissue is set while more than one remains
                    if (r.rep != `DCX_ZERO_REP) begin
                        next_r.rep = r.rep - `DCX_ONE_REP;
                    end
                    next_r.reissue = (r.rep > `DCX_ONE_REP);
                    unique case (op_i)
                        dcx_pkg::dcx_op_acc_multiply, dcx_pkg::dcx_op_acc_square,
                        dcx_pkg::dcx_op_acc_multiply_negated,
                        dcx_pkg::dcx_op_acc_multiply_subtract: begin
                            if (op_i == dcx_pkg::dcx_op_acc_multiply_negated) begin
                                acc_new = `DCX_ZERO_ACC - prod_ext;
                            end else if (op_i == dcx_pkg::dcx_op_acc_multiply_subtract) begin
                                acc_new = (acc_sel_i ? r.acc_b : r.acc_a) - prod_ext;
                                // accumulator write-back stores the other accumulator high word, bits 31:16, without rounding
                                next_r.wr_en = 1'b1;
                                next_r.wr_idx = dst_idx_i;
                                next_r.wr_data = acc_sel_i ? r.acc_a[31:16] : r.acc_b[31:16];
                            end else begin
                                acc_new = prod_ext;
                            end
                            // overflow: guard bits disagree with bit 31; saturate: beyond 40 bits
                            ovf = ~((&acc_new[`DCX_ACC_MSB:`DCX_ACC_SAT_BIT]) |
                                    ~(|acc_new[`DCX_ACC_MSB:`DCX_ACC_SAT_BIT]));
                            sat = (op_i == dcx_pkg::dcx_op_acc_multiply_subtract) &&
                                  ((acc_sel_i ? r.acc_b[`DCX_ACC_MSB] : r.acc_a[`DCX_ACC_MSB]) !=
                                   prod_ext[`DCX_ACC_MSB]) &&
                                  (acc_new[`DCX_ACC_MSB] == prod_ext[`DCX_ACC_MSB]);
                            if (acc_sel_i) begin
                                next_r.acc_b = acc_new;
                            end else begin
                                next_r.acc_a = acc_new;
                            end
                            if (op_i != dcx_pkg::dcx_op_acc_multiply_negated) begin
                                if (acc_sel_i) begin
                                    next_r.fl.acc_b_overflow = ovf;
                                    next_r.fl.acc_b_saturate = r.fl.acc_b_saturate | sat;
                                end else begin
                                    next_r.fl.acc_a_overflow = ovf;
                                    next_r.fl.acc_a_saturate = r.fl.acc_a_saturate | sat;
                                end
                            end
                        end
                        dcx_pkg::dcx_op_int_multiply, dcx_pkg::dcx_op_int_multiply_lit5: begin
                            // low word now, high word to the next register on the following edge
                            next_r.wr_en = 1'b1;
                            next_r.wr_idx = dst_idx_i;
                            next_r.wr_data = prod[15:0];
                            next_r.hi_word = prod[31:16];
                            next_r.pair_idx = dst_idx_i + 4'h1;
                            // busy covers the high-word cycle so no op is lost while it lands
                            next_r.busy = 1'b1;
                            next_r.st = dcx_pkg::dcx_st_third;
                        end
                        dcx_pkg::dcx_op_pop_double: begin
                            next_r.sp = r.sp - `DCX_SP_STEP;
                            next_r.pair_idx = dst_idx_i + 4'h1;
                            next_r.wr_idx = dst_idx_i;
                            next_r.cyc = `DCX_CYC_POP_D - 2'h1;
                            next_r.busy = 1'b1;
                            next_r.st = dcx_pkg::dcx_st_second;
                        end
                        dcx_pkg::dcx_op_push_double: begin
                            next_r.stack_wr = 1'b1;
                            next_r.stack_wr_data = src_a_i;
                            next_r.sp = r.sp + `DCX_SP_STEP;
                            next_r.hi_word = src_b_i;
                            next_r.cyc = `DCX_CYC_PUSH_D - 2'h1;
                            next_r.busy = 1'b1;
                            next_r.st = dcx_pkg::dcx_st_second;
                        end
                        dcx_pkg::dcx_op_pop_shadow: begin
                            next_r.fl = r.shadow;
                        end
                        dcx_pkg::dcx_op_push_shadow: begin
                            next_r.shadow = r.fl;
                        end
                        dcx_pkg::dcx_op_repeat_lit: begin
                            next_r.rep = {2'h0, lit14_i} + `DCX_ONE_REP;
                            next_r.reissue = 1'b0;
                        end
                        dcx_pkg::dcx_op_repeat_reg: begin
                            next_r.rep = src_a_i + `DCX_ONE_REP;
                            next_r.reissue = 1'b0;
                        end
                        dcx_pkg::dcx_op_return: begin
                            next_r.cyc = (ret_fast_i ? `DCX_CYC_RET_FAST : `DCX_CYC_RET) - 2'h1;
                            next_r.busy = 1'b1;
                            next_r.st = dcx_pkg::dcx_st_second;
                        end
                        dcx_pkg::dcx_op_power_save_op: begin
                            next_r.watchdog_timeout_flag = 1'b0;
                            next_r.sleep = ~lit1_i;
                            next_r.idle = lit1_i;
                        end
                        dcx_pkg::dcx_op_reset: begin
                            next_r.soft_reset = 1'b1;
                        end
                        dcx_pkg::dcx_op_rotate_left_carry: begin
                            rot = {src_a_i[14:0], r.fl.c};
                            next_r.fl.c = src_a_i[15];
                        end
                        dcx_pkg::dcx_op_rotate_left_plain: begin
                            rot = {src_a_i[14:0], src_a_i[15]};
                        end
                        dcx_pkg::dcx_op_rotate_right_carry: begin
                            rot = {r.fl.c, src_a_i[15:1]};
                            next_r.fl.c = src_a_i[0];
                        end
                        dcx_pkg::dcx_op_nop: begin
                        end
                        default: begin
                        end
                    endcase
                    if (op_i == dcx_pkg::dcx_op_rotate_left_carry || op_i == dcx_pkg::dcx_op_rotate_left_plain ||
                        op_i == dcx_pkg::dcx_op_rotate_right_carry) begin
                        next_r.fl.n = rot[15];
                        next_r.fl.z = (rot == 16'h0000);
                        next_r.wr_en = 1'b1;
                        next_r.wr_idx = dst_idx_i;
                        next_r.wr_data = rot;
                    end
                end
            end
            dcx_pkg::dcx_st_second: begin
                if (r.cyc == 2'h1) begin
                    next_r.busy = 1'b0;
                    next_r.st = dcx_pkg::dcx_st_idle;
                    if (op_i == dcx_pkg::dcx_op_pop_double) begin
                        next_r.wr_en = 1'b1;
                        next_r.wr_data = stack_rd_i;
                        next_r.sp = r.sp - `DCX_SP_STEP;
                        next_r.st = dcx_pkg::dcx_st_third;
                        next_r.busy = 1'b1;
                    end else if (op_i == dcx_pkg::dcx_op_push_double) begin
                        next_r.stack_wr = 1'b1;
                        next_r.stack_wr_data = r.hi_word;
                        next_r.sp = r.sp + `DCX_SP_STEP;
                    end
                end else begin
                    next_r.cyc = r.cyc - 2'h1;
                end
            end
            dcx_pkg::dcx_st_third: begin
                // second register of a pair
                next_r.wr_en = 1'b1;
                next_r.wr_idx = r.pair_idx;
                next_r.busy = 1'b0;
                next_r.wr_data = (op_i == dcx_pkg::dcx_op_pop_double) ? stack_rd_i : r.hi_word;
                next_r.st = dcx_pkg::dcx_st_idle;
            end
            default: begin
                next_r.st = dcx_pkg::dcx_st_idle;
            end
        endcase
        // combined flags are registered so the outputs come straight from flops
        next_r.ab_ovf = next_r.fl.acc_a_overflow | next_r.fl.acc_b_overflow;
        next_r.ab_sat = next_r.fl.acc_a_saturate | next_r.fl.acc_b_saturate;
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            r <= '0;
            r.sp <= `DCX_SP_RESET;
            r.st <= dcx_pkg::dcx_st_idle;
        end else begin
            r <= next_r;
        end
    end

    always_comb begin
        wr_en_o = r.wr_en;
        wr_idx_o = r.wr_idx;
        wr_data_o = r.wr_data;
        stack_wr_o = r.stack_wr;
        stack_wr_data_o = r.stack_wr_data;
        stack_ptr_o = r.sp;
        acc_a_o = r.acc_a;
        acc_b_o = r.acc_b;
        c_o = r.fl.c;
        n_o = r.fl.n;
        z_o = r.fl.z;
        acc_a_overflow_o = r.fl.acc_a_overflow;
        acc_b_overflow_o = r.fl.acc_b_overflow;
        acc_ab_overflow_o = r.ab_ovf;
        acc_a_saturate_o = r.fl.acc_a_saturate;
        acc_b_saturate_o = r.fl.acc_b_saturate;
        acc_ab_saturate_o = r.ab_sat;
        watchdog_timeout_flag_o = r.watchdog_timeout_flag;
        sleep_flag_o = r.sleep;
        idle_flag_o = r.idle;
        soft_reset_o = r.soft_reset;
        busy_o = r.busy;
        reissue_o = r.reissue;
        repeat_count_o = r.rep;
    end
endmodule : dcx_exec

/* File: test/dcx_exec_assertions.sv */
// checker for the execution unit: op results and sequencing timing
// assumes dcx_pkg compiled first and binding onto dcx_exec
`timescale 1ns/1ps
module dcx_exec_assertions (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    // issue side
    input wire logic op_valid_i,
    input wire dcx_pkg::dcx_op_t op_i,
    input wire logic acc_sel_i,
    input wire logic [3:0] dst_idx_i,
    input wire logic [15:0] src_a_i,
    input wire logic [15:0] src_b_i,
    input wire logic lit1_i,
    input wire logic ret_fast_i,
    // results
    input wire logic wr_en_o,
    input wire logic [3:0] wr_idx_o,
    input wire logic [15:0] wr_data_o,
    input wire logic [39:0] acc_a_o,
    input wire logic [39:0] acc_b_o,
    input wire logic c_o,
    input wire logic n_o,
    input wire logic z_o,
    input wire logic watchdog_timeout_flag_o,
    input wire logic sleep_flag_o,
    input wire logic idle_flag_o,
    input wire logic soft_reset_o,
    input wire logic busy_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i);
    logic take;
    logic signed [39:0] prod;
    logic signed [39:0] sq;
    logic [15:0] rl;
    logic [15:0] rr;
    assign take = op_valid_i && !busy_o;
    assign prod = $signed(src_a_i) * $signed(src_b_i);
    assign sq = $signed(src_a_i) * $signed(src_a_i);
    assign rl = {src_a_i[14:0], c_o};
    assign rr = {c_o, src_a_i[15:1]};
    property p_mpy;
        take && op_i == dcx_pkg::dcx_op_acc_multiply && !acc_sel_i |=> acc_a_o == $past(prod);
    endproperty
    a_mpy: assert property (p_mpy) else $error("acc multiply wrong");
    property p_sq;
        take && op_i == dcx_pkg::dcx_op_acc_square && acc_sel_i |=> acc_b_o == $past(sq);
    endproperty
    a_sq: assert property (p_sq) else $error("acc square wrong");
    property p_neg;
        take && op_i == dcx_pkg::dcx_op_acc_multiply_negated && !acc_sel_i
            |=> acc_a_o == -$past(prod) && $stable({c_o, n_o, z_o});
    endproperty
    a_neg: assert property (p_neg) else $error("negated multiply wrong");
    property p_msc;
        take && op_i == dcx_pkg::dcx_op_acc_multiply_subtract && !acc_sel_i
            |=> acc_a_o == $past(acc_a_o) - $past(prod);
    endproperty
    a_msc: assert property (p_msc) else $error("multiply subtract wrong");
    property p_imul;
        take && op_i == dcx_pkg::dcx_op_int_multiply |=> wr_en_o && wr_idx_o == $past(dst_idx_i)
            ##1 wr_en_o && wr_idx_o == $past(dst_idx_i, 2) + 4'h1;
    endproperty
    a_imul: assert property (p_imul) else $error("int multiply pairing wrong");
    property p_ret;
        take && op_i == dcx_pkg::dcx_op_return && !ret_fast_i |=> busy_o [*2] ##1 !busy_o;
    endproperty
    a_ret: assert property (p_ret) else $error("return length wrong");
    property p_pwr;
        take && op_i == dcx_pkg::dcx_op_power_save_op
            |=> ($past(lit1_i) ? idle_flag_o : sleep_flag_o) && !watchdog_timeout_flag_o;
    endproperty
    a_pwr: assert property (p_pwr) else $error("power save flags wrong");
    property p_rst;
        take && op_i == dcx_pkg::dcx_op_reset |=> soft_reset_o ##1 !soft_reset_o;
    endproperty
    a_rst: assert property (p_rst) else $error("soft reset pulse wrong");
    property p_rlc;
        take && op_i == dcx_pkg::dcx_op_rotate_left_carry |=> wr_data_o == $past(rl) && c_o == $past(src_a_i[15]);
    endproperty
    a_rlc: assert property (p_rlc) else $error("rotate left carry wrong");
    property p_rrc;
        take && op_i == dcx_pkg::dcx_op_rotate_right_carry |=> wr_data_o == $past(rr) && c_o == $past(src_a_i[0]);
    endproperty
    a_rrc: assert property (p_rrc) else $error("rotate right carry wrong");
endmodule : dcx_exec_assertions

bind dcx_exec dcx_exec_assertions u_chk (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .op_valid_i(op_valid_i),
    .op_i(op_i), .acc_sel_i(acc_sel_i), .dst_idx_i(dst_idx_i), .src_a_i(src_a_i), .src_b_i(src_b_i),
    .lit1_i(lit1_i), .ret_fast_i(ret_fast_i), .wr_en_o(wr_en_o), .wr_idx_o(wr_idx_o), .wr_data_o(wr_data_o),
    .acc_a_o(acc_a_o), .acc_b_o(acc_b_o), .c_o(c_o), .n_o(n_o), .z_o(z_o),
    .watchdog_timeout_flag_o(watchdog_timeout_flag_o), .sleep_flag_o(sleep_flag_o), .idle_flag_o(idle_flag_o),
    .soft_reset_o(soft_reset_o), .busy_o(busy_o));

/* File: test/dcx_exec_tb.sv */
// self-checking bench for the execution unit
// assumes design files and checker compiled before it
`timescale 1ns/1ps
module dcx_exec_tb;
    logic ref_clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic op_valid_i = 1'b0;
    dcx_pkg::dcx_op_t op_i = dcx_pkg::dcx_op_nop;
    logic acc_sel_i = 1'b0, a_signed_i = 1'b1, b_signed_i = 1'b1, lit1_i = 1'b0, ret_fast_i = 1'b0;
    logic [3:0] dst_idx_i = 4'h2;
    logic [15:0] src_a_i = 16'h0000, src_b_i = 16'h0000, stack_rd_i = 16'h1234;
    logic [13:0] lit14_i = 14'h0000;
    logic [4:0] lit5_i = 5'h00;
    logic wr_en_o, c_o, n_o, z_o, ovf_a, watchdog_timeout_flag, sleep, idle, soft_reset_o, busy_o, stack_wr, reissue;
    logic [3:0] wr_idx_o;
    logic [15:0] wr_data_o, stack_ptr_o, repeat_count_o, stack_wr_data;
    logic [39:0] acc_a_o, acc_b_o;
    int err_count = 0;
    int n_tests = 0;
    // 0xffff * 0xfffe for uu, us, su, ss operand signedness
    logic [31:0] mul_exp [4] = '{32'hfffd_0002, 32'hfffe_0002, 32'hffff_0002, 32'h0000_0002};
    always #12.5 ref_clk_i = ~ref_clk_i;
    dcx_exec dut (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .op_valid_i(op_valid_i), .op_i(op_i),
        .acc_sel_i(acc_sel_i), .dst_idx_i(dst_idx_i), .src_a_i(src_a_i), .src_b_i(src_b_i),
        .a_signed_i(a_signed_i), .b_signed_i(b_signed_i), .lit14_i(lit14_i), .lit5_i(lit5_i), .lit1_i(lit1_i),
        .ret_fast_i(ret_fast_i), .stack_rd_i(stack_rd_i), .wr_en_o(wr_en_o), .wr_idx_o(wr_idx_o),
        .wr_data_o(wr_data_o), .stack_wr_o(stack_wr), .stack_wr_data_o(stack_wr_data), .stack_ptr_o(stack_ptr_o),
        .acc_a_o(acc_a_o), .acc_b_o(acc_b_o), .c_o(c_o), .n_o(n_o), .z_o(z_o), .acc_a_overflow_o(ovf_a),
        .acc_b_overflow_o(), .acc_ab_overflow_o(), .acc_a_saturate_o(), .acc_b_saturate_o(),
        .acc_ab_saturate_o(), .watchdog_timeout_flag_o(watchdog_timeout_flag), .sleep_flag_o(sleep), .idle_flag_o(idle),
        .soft_reset_o(soft_reset_o), .busy_o(busy_o), .reissue_o(reissue), .repeat_count_o(repeat_count_o));
    task automatic chk(input string name, input logic [39:0] seen, input logic [39:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic step;
        @(posedge ref_clk_i);
        #2;
    endtask : step
    // returns 2 ns after the taking edge, when first results have landed
    task automatic issue(input dcx_pkg::dcx_op_t op, input logic [15:0] a, input logic [15:0] b);
        step();
        for (int k = 0; k < 8 && busy_o !== 1'b0; k++) step();
        op_i = op;
        src_a_i = a;
        src_b_i = b;
        op_valid_i = 1'b1;
        step();
        op_valid_i = 1'b0;
    endtask : issue
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : conclude
    initial begin
        #(25 * 5000);
        err_count++;
        conclude();
    end
    initial begin
        logic [31:0] e;
        logic [2:0] fl;
        repeat (10) @(posedge ref_clk_i);
        #2;
        arst_n_i = 1'b1;
        chk("sp_reset", stack_ptr_o, 40'h800);
        chk("acc_reset", acc_a_o, 40'h0);
        chk("busy_reset", busy_o, 40'h0);
        issue(dcx_pkg::dcx_op_acc_multiply, 16'h0003, 16'hfffb);
        chk("mpy", acc_a_o, 40'hff_ffff_fff1);
        chk("mpy_ovf", ovf_a, 40'h0);
        issue(dcx_pkg::dcx_op_acc_multiply_subtract, 16'h0002, 16'h0004);
        chk("msc", acc_a_o, 40'hff_ffff_ffe9);
        acc_sel_i = 1'b1;
        issue(dcx_pkg::dcx_op_acc_square, 16'h0007, 16'h0000);
        chk("square", acc_b_o, 40'h31);
        acc_sel_i = 1'b0;
        issue(dcx_pkg::dcx_op_rotate_left_carry, 16'h8000, 16'h0000);
        chk("rlc", {c_o, z_o, wr_data_o}, 40'h30000);
        issue(dcx_pkg::dcx_op_rotate_right_carry, 16'h0001, 16'h0000);
        chk("rrc", {c_o, n_o, wr_data_o}, 40'h38000);
        issue(dcx_pkg::dcx_op_rotate_left_plain, 16'h8001, 16'h0000);
        chk("rotate_left_plain", {c_o, n_o, wr_data_o}, 40'h20003);
        fl = {c_o, n_o, z_o};
        issue(dcx_pkg::dcx_op_acc_multiply_negated, 16'h0006, 16'h0006);
        chk("neg", acc_a_o, 40'hff_ffff_ffdc);
        issue(dcx_pkg::dcx_op_push_shadow, 16'h0000, 16'h0000);
        issue(dcx_pkg::dcx_op_push_double, 16'h1111, 16'h2222);
        chk("push_lo", {stack_wr, stack_wr_data}, 40'h11111);
        step();
        chk("push_hi", {stack_wr, stack_wr_data}, 40'h12222);
        chk("flags_kept", {c_o, n_o, z_o}, fl);
        issue(dcx_pkg::dcx_op_rotate_left_carry, 16'h0000, 16'h0000);
        issue(dcx_pkg::dcx_op_pop_shadow, 16'h0000, 16'h0000);
        chk("shadow_restore", {c_o, n_o, z_o}, fl);
        for (int m = 0; m < 4; m++) begin
            a_signed_i = m[1];
            b_signed_i = m[0];
            issue(dcx_pkg::dcx_op_int_multiply, 16'hffff, 16'hfffe);
            e = mul_exp[m];
            chk("mul_lo", {wr_en_o, wr_idx_o, wr_data_o}, {1'b1, 4'h2, e[15:0]});
            step();
            chk("mul_hi", {wr_en_o, wr_idx_o, wr_data_o}, {1'b1, 4'h3, e[31:16]});
        end
        a_signed_i = 1'b1;
        lit5_i = 5'h1f;
        issue(dcx_pkg::dcx_op_int_multiply_lit5, 16'hfffe, 16'h0000);
        chk("lit5_lo", wr_data_o, 40'hffc2);
        step();
        chk("lit5_hi", wr_data_o, 40'hffff);
        issue(dcx_pkg::dcx_op_pop_double, 16'h0000, 16'h0000);
        step();
        chk("pop_first", {wr_en_o, wr_idx_o, wr_data_o}, 40'h121234);
        step();
        chk("pop_second", {wr_en_o, wr_idx_o}, 40'h13);
        chk("pop_sp", stack_ptr_o, 40'h800);
        for (int m = 0; m < 2; m++) begin
            lit1_i = m[0];
            issue(dcx_pkg::dcx_op_power_save_op, 16'h0000, 16'h0000);
            chk("pwrsave", {watchdog_timeout_flag, m[0] ? idle : sleep}, 40'h1);
            ret_fast_i = m[0];
            issue(dcx_pkg::dcx_op_return, 16'h0000, 16'h0000);
            chk("ret_busy", busy_o, 40'h1);
            step();
            chk("ret_len", busy_o, m[0] ? 40'h0 : 40'h1);
        end
        issue(dcx_pkg::dcx_op_reset, 16'h0000, 16'h0000);
        chk("soft_reset", soft_reset_o, 40'h1);
        issue(dcx_pkg::dcx_op_repeat_reg, 16'h0001, 16'h0000);
        chk("rep_reg", repeat_count_o, 40'h2);
        issue(dcx_pkg::dcx_op_nop, 16'h0000, 16'h0000);
        chk("rep_dec", {reissue, repeat_count_o}, 40'h10001);
        issue(dcx_pkg::dcx_op_nop, 16'h0000, 16'h0000);
        lit14_i = 14'h3fff;
        issue(dcx_pkg::dcx_op_repeat_lit, 16'h0000, 16'h0000);
        chk("rep_lit", repeat_count_o, 40'h4000);
        arst_n_i = 1'b0;
        step();
        arst_n_i = 1'b1;
        chk("rep_cleared", repeat_count_o, 40'h0);
        conclude();
    end
endmodule : dcx_exec_tb
